// ==== core/mrp_pkg.sv ====
// Shared constants and carriers for the receive status and pause control block.
package mrp_pkg;
   localparam logic [7:0] MRP_OFF_CTRL = 8'h00;
   localparam logic [7:0] MRP_OFF_STAT = 8'h04;
   localparam logic [7:0] MRP_OFF_BUFL = 8'h08;
   localparam logic [7:0] MRP_OFF_BUFH = 8'h0C;
   localparam int MRP_C_LPBK = 0;
   localparam int MRP_C_FDX = 1;
   localparam int MRP_C_G1000 = 2;
   localparam int MRP_C_AR = 3;
   localparam int MRP_C_AER = 4;
   localparam int MRP_C_FCEN = 5;
   localparam logic [5:0] MRP_CTRL_RST = 6'h22;
   localparam int MRP_B_OWN = 31;
   localparam int MRP_B_LS = 28;
   localparam int MRP_B_FIFO_OVERRUN_FLAG = 23;
   localparam int MRP_B_RWT = 22;
   localparam int MRP_B_RES = 21;
   localparam int MRP_B_RUNT = 20;
   localparam int MRP_B_CRC = 19;
   localparam int MRP_B_PID = 17;
   localparam int MRP_B_IPF = 16;
   localparam int MRP_B_UDP_CHECKSUM_BAD = 15;
   localparam int MRP_B_TCP_CHECKSUM_BAD = 14;
   localparam int MRP_B_TAG = 16;
   localparam logic [15:0] MRP_VLAN_TPID = 16'h8100;
   localparam logic [13:0] MRP_LEN_GUARD = 14'h1000;
   localparam logic [13:0] MRP_RUNT_MIN = 14'h0040;
   localparam logic [15:0] MRP_PAUSE_STOP = 16'hFFFF;
   localparam logic [15:0] MRP_PAUSE_GO = 16'h0000;
   typedef struct packed {
      logic [2:0] priority_field;
      logic cfi;
      logic [3:0] vlan_id_high;
      logic [7:0] vlan_id_low;
   } mrp_vlan_t;
   typedef struct packed {
      logic [13:0] len;
      logic crc_err;
      logic alignment_error;
      logic fifo_ovf;
      logic [1:0] proto;
      logic ipv4_bad;
      logic udp_bad;
      logic tcp_bad;
      logic last_seg;
      logic [15:0] tag_type;
      mrp_vlan_t tag;
   } mrp_rx_info_t;
   typedef struct packed {
      logic [31:0] w3;
      logic [31:0] w2;
      logic [31:0] w1;
      logic [31:0] w0;
   } mrp_desc_t;
   typedef enum logic [1:0] {
      MRP_J_IDLE = 2'b00,
      MRP_J_WAIT = 2'b01,
      MRP_J_JAM = 2'b11
   } mrp_jam_t;
endpackage

// ==== core/mrp_backoff.sv ====
// Pause backoff timer counting 512-bit-time quanta.
`timescale 1ns/1ps
`default_nettype none
module mrp_backoff
   import mrp_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic pause_i,
   input wire logic [15:0] time_i,
   input wire logic tx_busy_i,
   input wire logic slot_tick_i,
   output logic hold_o
);
   logic pend_q;
   logic [15:0] pend_time_q;
   logic [15:0] cnt_q;

   // A nonzero pause taken during a frame is parked until the frame ends.
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pend_q <= 1'b0;
         pend_time_q <= MRP_PAUSE_GO;
         cnt_q <= MRP_PAUSE_GO;
         hold_o <= 1'b0;
      end
      else if (pause_i && time_i == MRP_PAUSE_GO)
      begin
         pend_q <= 1'b0;
         cnt_q <= MRP_PAUSE_GO;
         hold_o <= 1'b0;
      end
      else if (pause_i && tx_busy_i)
      begin
         pend_q <= 1'b1;
         pend_time_q <= time_i;
      end
      else if (pause_i || (pend_q && !tx_busy_i))
      begin
         pend_q <= 1'b0;
         cnt_q <= pause_i ? time_i : pend_time_q;
         hold_o <= 1'b1;
      end
      else if (hold_o && slot_tick_i)
      begin
         cnt_q <= cnt_q - 16'h0001;
         hold_o <= (cnt_q != 16'h0001);
      end
   end

   property p_zero_release;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      pause_i && time_i == MRP_PAUSE_GO |=> !hold_o && !pend_q;
   endproperty
   a_zero_release: assert property (p_zero_release)
      else $error("Zero pause did not release the hold.");

   property p_defer;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      pause_i && time_i != MRP_PAUSE_GO && tx_busy_i && !hold_o |=> !hold_o && pend_q;
   endproperty
   a_defer: assert property (p_defer)
      else $error("Backoff began during a frame.");
endmodule
`default_nettype wire

// ==== core/mrp_core.sv ====
// Receive status write-back, loopback, collision jam and pause flow control.
`timescale 1ns/1ps
`default_nettype none
module mrp_core
   import mrp_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] tx_d_i,
   input wire logic tx_en_i,
   input wire logic tx_preamble_i,
   input wire logic tx_busy_i,
   input wire logic [7:0] phy_rxd_i,
   input wire logic phy_rx_dv_i,
   output logic [7:0] phy_txd_o,
   output logic phy_tx_en_o,
   output logic [7:0] mac_rxd_o,
   output logic mac_rx_dv_o,
   output logic collision_o,
   output logic jam_o,
   input wire logic rx_done_i,
   input wire mrp_rx_info_t rx_info_i,
   output logic desc_wr_o,
   output mrp_desc_t desc_o,
   output logic frame_drop_o,
   output logic strip_tag_o,
   input wire logic autoneg_fc_i,
   input wire logic desc_avail_i,
   output logic pause_tx_req_o,
   output logic [15:0] pause_tx_time_o,
   input wire logic pause_tx_ack_i,
   input wire logic pause_rx_i,
   input wire logic [15:0] pause_rx_time_i,
   input wire logic slot_tick_i,
   output logic tx_pause_hold_o
);
   logic [5:0] ctrl_q;
   logic [31:0] bufl_q;
   logic [31:0] bufh_q;
   logic [7:0] coll_cnt_q;
   logic remote_paused_q;
   logic hold_w;
   logic fc_on;
   logic half_dx;
   logic collide;
   logic wb_req;
   logic wb_wr;
   logic [31:0] ctrl_wr;
   mrp_jam_t jam_q;
   mrp_jam_t jam_d;
   // Merges write data into a register under the byte enables.
   function automatic logic [31:0] mrp_merge(input logic [31:0] old,
                                             input logic [31:0] din,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            r[i*8 +: 8] = din[i*8 +: 8];
      end
      return r;
   endfunction
   // True when any receive error feeds the summary bit.
   function automatic logic mrp_any_err(input mrp_rx_info_t f);
      return f.crc_err || f.alignment_error || (f.len < MRP_RUNT_MIN)
             || (f.len > MRP_LEN_GUARD);
   endfunction
   // True when the frame may be handed to the host.
   function automatic logic mrp_accept(input mrp_rx_info_t f,
                                       input logic [5:0] c);
      return (!(f.len < MRP_RUNT_MIN) || c[MRP_C_AR])
             && (!f.crc_err || c[MRP_C_AER]);
   endfunction
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Writes land at the edge that sees ack, while the master still holds the request.
   assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign ctrl_wr = mrp_merge({26'h0000000, ctrl_q}, wb_dat_i, wb_sel_i);
   assign fc_on = ctrl_q[MRP_C_FDX] && ctrl_q[MRP_C_FCEN] && autoneg_fc_i;
   assign half_dx = !ctrl_q[MRP_C_FDX] && !ctrl_q[MRP_C_G1000];
   assign collide = half_dx && tx_en_i && phy_rx_dv_i && !ctrl_q[MRP_C_LPBK];
   // Slave answers one cycle after the request and drops ack after one cycle.
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_req;
   end
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ctrl_q <= MRP_CTRL_RST;
         bufl_q <= 32'h00000000;
         bufh_q <= 32'h00000000;
      end
      else if (wb_wr)
      begin
         case (wb_adr_i)
            MRP_OFF_CTRL: ctrl_q <= ctrl_wr[5:0];
            MRP_OFF_BUFL: bufl_q <= mrp_merge(bufl_q, wb_dat_i, wb_sel_i);
            MRP_OFF_BUFH: bufh_q <= mrp_merge(bufh_q, wb_dat_i, wb_sel_i);
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end
   // Unmapped addresses read as zero and writes to them are dropped.
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         wb_dat_o <= 32'h00000000;
      end
      else if (wb_req && !wb_we_i)
      begin
         case (wb_adr_i)
            MRP_OFF_CTRL: wb_dat_o <= {26'h0000000, ctrl_q};
            MRP_OFF_STAT: wb_dat_o <= {16'h0000, coll_cnt_q, 4'h0, pause_tx_req_o,
                                       remote_paused_q, tx_pause_hold_o, fc_on};
            MRP_OFF_BUFL: wb_dat_o <= bufl_q;
            MRP_OFF_BUFH: wb_dat_o <= bufh_q;
            default: wb_dat_o <= 32'h00000000;
         endcase
      end
   end
   // Loopback keeps transmit away from the PHY and feeds it to receive.
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         phy_txd_o <= 8'h00;
         phy_tx_en_o <= 1'b0;
         mac_rxd_o <= 8'h00;
         mac_rx_dv_o <= 1'b0;
      end
      else
      begin
         phy_txd_o <= ctrl_q[MRP_C_LPBK] ? 8'h00 : tx_d_i;
         phy_tx_en_o <= tx_en_i && !ctrl_q[MRP_C_LPBK];
         mac_rxd_o <= ctrl_q[MRP_C_LPBK] ? tx_d_i : phy_rxd_i;
         mac_rx_dv_o <= ctrl_q[MRP_C_LPBK] ? tx_en_i : phy_rx_dv_i;
      end
   end
   // The preamble signal covers the JK pair at 100 Mb/s.
   always_comb
   begin
      jam_d = jam_q;
      case (jam_q)
         MRP_J_IDLE:
            if (collide)
               jam_d = tx_preamble_i ? MRP_J_WAIT : MRP_J_JAM;
         MRP_J_WAIT:
            if (!tx_preamble_i)
               jam_d = MRP_J_JAM;
         MRP_J_JAM: jam_d = MRP_J_IDLE;
         default: jam_d = MRP_J_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         jam_q <= MRP_J_IDLE;
         jam_o <= 1'b0;
         collision_o <= 1'b0;
         coll_cnt_q <= 8'h00;
      end
      else
      begin
         jam_q <= jam_d;
         jam_o <= (jam_d == MRP_J_JAM);
         collision_o <= collide;
         if (collide && jam_q == MRP_J_IDLE && coll_cnt_q != 8'hFF)
         begin
            coll_cnt_q <= coll_cnt_q + 8'h01;
         end
      end
   end
   // Status write-back builds all four descriptor words in one cycle.
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         desc_wr_o <= 1'b0;
         frame_drop_o <= 1'b0;
         strip_tag_o <= 1'b0;
         desc_o <= '0;
      end
      else
      begin
         desc_wr_o <= rx_done_i && mrp_accept(rx_info_i, ctrl_q);
         frame_drop_o <= rx_done_i && !mrp_accept(rx_info_i, ctrl_q);
         strip_tag_o <= rx_done_i && rx_info_i.tag_type == MRP_VLAN_TPID;
         if (rx_done_i)
         begin
            desc_o.w0 <= 32'h00000000;
            desc_o.w0[MRP_B_OWN] <= 1'b0;
            desc_o.w0[MRP_B_LS] <= rx_info_i.last_seg;
            desc_o.w0[MRP_B_FIFO_OVERRUN_FLAG] <= rx_info_i.fifo_ovf;
            desc_o.w0[MRP_B_RWT] <= rx_info_i.len > MRP_LEN_GUARD;
            desc_o.w0[MRP_B_RES] <= rx_info_i.last_seg && mrp_any_err(rx_info_i);
            desc_o.w0[MRP_B_RUNT] <= rx_info_i.len < MRP_RUNT_MIN;
            desc_o.w0[MRP_B_CRC] <= rx_info_i.crc_err;
            desc_o.w0[MRP_B_PID +: 2] <= rx_info_i.proto;
            desc_o.w0[MRP_B_IPF] <= rx_info_i.ipv4_bad;
            desc_o.w0[MRP_B_UDP_CHECKSUM_BAD] <= rx_info_i.udp_bad;
            desc_o.w0[MRP_B_TCP_CHECKSUM_BAD] <= rx_info_i.tcp_bad;
            desc_o.w0[13:0] <= rx_info_i.last_seg ? rx_info_i.len : 14'h0000;
            desc_o.w1 <= 32'h00000000;
            if (rx_info_i.tag_type == MRP_VLAN_TPID)
            begin
               desc_o.w1[MRP_B_TAG] <= 1'b1;
               desc_o.w1[15:0] <= rx_info_i.tag;
            end
            desc_o.w2 <= bufl_q;
            desc_o.w3 <= bufh_q;
         end
      end
   end
   // One pause request is outstanding at a time; the ack marks it sent.
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pause_tx_req_o <= 1'b0;
         pause_tx_time_o <= MRP_PAUSE_GO;
         remote_paused_q <= 1'b0;
      end
      else if (pause_tx_req_o)
      begin
         if (pause_tx_ack_i)
         begin
            pause_tx_req_o <= 1'b0;
            remote_paused_q <= (pause_tx_time_o == MRP_PAUSE_STOP);
         end
      end
      else if (fc_on && !desc_avail_i && !remote_paused_q)
      begin
         pause_tx_req_o <= 1'b1;
         pause_tx_time_o <= MRP_PAUSE_STOP;
      end
      else if (desc_avail_i && remote_paused_q)
      begin
         pause_tx_req_o <= 1'b1;
         pause_tx_time_o <= MRP_PAUSE_GO;
      end
   end
   mrp_backoff u_backoff (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .pause_i(pause_rx_i && fc_on),
      .time_i(pause_rx_time_i),
      .tx_busy_i(tx_busy_i),
      .slot_tick_i(slot_tick_i),
      .hold_o(hold_w)
   );
   // The hold gates data frames only; the pause request path ignores it.
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         tx_pause_hold_o <= 1'b0;
      else
         tx_pause_hold_o <= hold_w;
   end
   property p_guard;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      rx_done_i && rx_info_i.len > MRP_LEN_GUARD && !rx_info_i.crc_err
      |=> desc_wr_o && desc_o.w0[MRP_B_RWT];
   endproperty
   a_guard: assert property (p_guard)
      else $error("Overlong frame not flagged.");
   property p_runt_drop;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      rx_done_i && rx_info_i.len < MRP_RUNT_MIN && !ctrl_q[MRP_C_AR]
      |=> frame_drop_o && !desc_wr_o;
   endproperty
   a_runt_drop: assert property (p_runt_drop)
      else $error("Runt delivered while not allowed.");
   property p_crc_drop;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      rx_done_i && rx_info_i.crc_err && !ctrl_q[MRP_C_AER] |=> !desc_wr_o;
   endproperty
   a_crc_drop: assert property (p_crc_drop)
      else $error("CRC frame delivered while not allowed.");
   property p_summary;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      desc_wr_o && desc_o.w0[MRP_B_LS]
      && (desc_o.w0[MRP_B_CRC] || desc_o.w0[MRP_B_RUNT] || desc_o.w0[MRP_B_RWT])
      |-> desc_o.w0[MRP_B_RES];
   endproperty
   a_summary: assert property (p_summary)
      else $error("Error summary missing.");
   property p_tag;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      rx_done_i && rx_info_i.tag_type == MRP_VLAN_TPID
      |=> strip_tag_o && desc_o.w1[MRP_B_TAG] && desc_o.w1[15:0] == $past(rx_info_i.tag);
   endproperty
   a_tag: assert property (p_tag)
      else $error("Value_a not captured.");
   property p_owner;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      desc_wr_o |-> !desc_o.w0[MRP_B_OWN] && desc_o.w0[MRP_B_LS] == $past(rx_info_i.last_seg);
   endproperty
   a_owner: assert property (p_owner)
      else $error("Ownership or last segment wrong.");
   property p_no_coll;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      ctrl_q[MRP_C_FDX] || ctrl_q[MRP_C_G1000] |=> !collision_o;
   endproperty
   a_no_coll: assert property (p_no_coll)
      else $error("Collision outside half duplex.");
   property p_preamble;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      jam_q == MRP_J_WAIT && tx_preamble_i |=> !jam_o;
   endproperty
   a_preamble: assert property (p_preamble)
      else $error("Jam started inside the preamble.");
   property p_loop;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      ctrl_q[MRP_C_LPBK] && tx_en_i |=> mac_rx_dv_o && !phy_tx_en_o;
   endproperty
   a_loop: assert property (p_loop)
      else $error("Loopback reached the PHY.");
   property p_stop;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      $rose(pause_tx_req_o) && !desc_avail_i
      |-> pause_tx_time_o == MRP_PAUSE_STOP && $past(fc_on);
   endproperty
   a_stop: assert property (p_stop)
      else $error("Wrong pause time when out of descriptors.");
endmodule
`default_nettype wire

// ==== testbench/mrp_peer.sv ====
// Far-side model: PHY line with optional external loopback, and the PAUSE frame sender.
`timescale 1ns/1ps
`default_nettype none
module mrp_peer (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ext_lpbk_i,
   input wire logic slow_i,
   input wire logic [7:0] txd_i,
   input wire logic tx_en_i,
   input wire logic [7:0] line_d_i,
   input wire logic line_dv_i,
   input wire logic pause_req_i,
   output logic [7:0] rxd_o,
   output logic rx_dv_o,
   output logic pause_ack_o
);
   logic [7:0] lb_d_q;
   logic lb_dv_q;
   logic [7:0] last_q;
   logic [2:0] wait_q;
   // In external loopback the PHY returns each transmitted byte one cycle later.
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         lb_d_q <= 8'h00;
         lb_dv_q <= 1'b0;
      end
      else
      begin
         lb_d_q <= txd_i;
         lb_dv_q <= tx_en_i & ext_lpbk_i;
      end
   end
   assign rx_dv_o = ext_lpbk_i ? lb_dv_q : line_dv_i;
   // An idle line shows the inverse of its last byte so that stale data never matches.
   assign rxd_o = !rx_dv_o ? ~last_q : (ext_lpbk_i ? lb_d_q : line_d_i);
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         last_q <= 8'h00;
      else if (rx_dv_o)
         last_q <= rxd_o;
   end
   // The sender answers a PAUSE request at once or after a few cycles of other traffic.
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pause_ack_o <= 1'b0;
         wait_q <= 3'h0;
      end
      else if (pause_ack_o)
         pause_ack_o <= 1'b0;
      else if (!pause_req_i)
         wait_q <= slow_i ? 3'h5 : 3'h0;
      else if (wait_q == 3'h0)
         pause_ack_o <= 1'b1;
      else
         wait_q <= wait_q - 3'h1;
   end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Bench for the receive status and pause block: a table of frames, then link cases.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import mrp_pkg::*;
;
   typedef struct packed {
      logic [13:0] len;
      logic [9:0] f;
      logic [5:0] c;
      logic drop;
   } mrp_row_t;
   logic sys_clk_i = 1'b0, reset_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00, tx_d_i = 8'h00, line_d = 8'h00, phy_rxd, phy_txd_o, mac_rxd_o;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic tx_en_i = 1'b0, tx_preamble_i = 1'b0, tx_busy_i = 1'b0, line_dv = 1'b0, rx_done_i = 1'b0;
   logic wb_ack_o, phy_rx_dv, phy_tx_en_o, mac_rx_dv_o, collision_o, jam_o;
   logic desc_wr_o, frame_drop_o, strip_tag_o, pause_tx_req_o, pause_tx_ack, tx_pause_hold_o;
   logic autoneg_fc_i = 1'b0, desc_avail_i = 1'b1, pause_rx_i = 1'b0, slot_tick_i = 1'b0;
   logic ext_lpbk = 1'b0, slow = 1'b0;
   logic [15:0] pause_tx_time_o, pause_rx_time_i = 16'h0000;
   mrp_rx_info_t rx_info_i = '0;
   mrp_desc_t desc_o;
   int mismatches = 0, n_compared = 0;
   // Row flags: 9:8 protocol, 7 last, 6 crc, 5 alignment, 4 overflow, 3:1 ip/udp/tcp, 0 tagged.
   mrp_row_t rows [11] = '{
      '{14'h0064, 10'h181, 6'h22, 1'b0}, '{14'h003F, 10'h080, 6'h22, 1'b1},
      '{14'h003F, 10'h080, 6'h2A, 1'b0}, '{14'h0040, 10'h080, 6'h22, 1'b0},
      '{14'h00C8, 10'h0C1, 6'h22, 1'b1}, '{14'h00C8, 10'h0C0, 6'h32, 1'b0},
      '{14'h1001, 10'h080, 6'h22, 1'b0}, '{14'h1000, 10'h080, 6'h22, 1'b0},
      '{14'h012C, 10'h2B8, 6'h22, 1'b0}, '{14'h012C, 10'h387, 6'h22, 1'b0},
      '{14'h01F4, 10'h100, 6'h22, 1'b0}};

   mrp_peer i_peer (.clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ext_lpbk_i(ext_lpbk),
      .slow_i(slow), .txd_i(phy_txd_o), .tx_en_i(phy_tx_en_o), .line_d_i(line_d),
      .line_dv_i(line_dv), .pause_req_i(pause_tx_req_o), .rxd_o(phy_rxd), .rx_dv_o(phy_rx_dv),
      .pause_ack_o(pause_tx_ack));
   mrp_core i_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_d_i(tx_d_i),
      .tx_en_i(tx_en_i), .tx_preamble_i(tx_preamble_i), .tx_busy_i(tx_busy_i),
      .phy_rxd_i(phy_rxd), .phy_rx_dv_i(phy_rx_dv), .phy_txd_o(phy_txd_o),
      .phy_tx_en_o(phy_tx_en_o), .mac_rxd_o(mac_rxd_o), .mac_rx_dv_o(mac_rx_dv_o),
      .collision_o(collision_o), .jam_o(jam_o), .rx_done_i(rx_done_i), .rx_info_i(rx_info_i),
      .desc_wr_o(desc_wr_o), .desc_o(desc_o), .frame_drop_o(frame_drop_o),
      .strip_tag_o(strip_tag_o), .autoneg_fc_i(autoneg_fc_i), .desc_avail_i(desc_avail_i),
      .pause_tx_req_o(pause_tx_req_o), .pause_tx_time_o(pause_tx_time_o),
      .pause_tx_ack_i(pause_tx_ack), .pause_rx_i(pause_rx_i),
      .pause_rx_time_i(pause_rx_time_i), .slot_tick_i(slot_tick_i),
      .tx_pause_hold_o(tx_pause_hold_o));

   always #50 sys_clk_i = ~sys_clk_i;

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic give_up(input string n);
      $display("unexpected %s expected answer seen timeout", n);
      mismatches++;
      wrap_up();
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   function automatic logic probe(input int s);
      case (s)
         0: return pause_tx_req_o;
         1: return tx_pause_hold_o;
         2: return jam_o;
         default: return mac_rx_dv_o;
      endcase
   endfunction

   task automatic wait_sig(input int s, input logic v);
      for (int k = 0; k < 40; k++)
      begin
         @(posedge sys_clk_i);
         #1;
         if (probe(s) === v)
            return;
      end
      give_up($sformatf("signal %0d", s));
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge sys_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      for (k = 0; k < 20; k++)
      begin
         @(posedge sys_clk_i);
         if (wb_ack_o === 1'b1)
            break;
      end
      if (k == 20)
         give_up("bus ack");
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic pulse(input logic is_pause, input logic [15:0] n);
      @(posedge sys_clk_i);
      pause_rx_i <= is_pause;
      slot_tick_i <= ~is_pause;
      pause_rx_time_i <= n;
      @(posedge sys_clk_i);
      pause_rx_i <= 1'b0;
      slot_tick_i <= 1'b0;
   endtask

   function automatic mrp_rx_info_t to_info(input mrp_row_t r);
      mrp_rx_info_t i;
      i = '0;
      i.len = r.len;
      i.proto = r.f[9:8];
      {i.last_seg, i.crc_err, i.alignment_error, i.fifo_ovf} = r.f[7:4];
      {i.ipv4_bad, i.udp_bad, i.tcp_bad} = r.f[3:1];
      i.tag_type = r.f[0] ? 16'h8100 : 16'h0800;
      i.tag = {2'h2, r.len};
      return i;
   endfunction

   function automatic logic [31:0] exp_w0(input mrp_rx_info_t i);
      logic rx_length_guard_expired;
      logic runt;
      rx_length_guard_expired = i.len > 14'h1000;
      runt = i.len < 14'h0040;
      return {3'h0, i.last_seg, 4'h0, i.fifo_ovf, rx_length_guard_expired,
         i.last_seg & (i.crc_err | runt | rx_length_guard_expired | i.alignment_error), runt, i.crc_err, i.proto,
         i.ipv4_bad, i.udp_bad, i.tcp_bad, i.last_seg ? i.len : 14'h0000};
   endfunction

   initial
   begin
      repeat (12) @(posedge sys_clk_i);
      #1;
      chk("outputs in reset", 32'h0, 32'({desc_wr_o, frame_drop_o, jam_o, collision_o,
         pause_tx_req_o, tx_pause_hold_o, mac_rx_dv_o, phy_tx_en_o, wb_ack_o}));
      @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      wb(1'b0, 8'h00, 32'h0);
      chk("ctrl", 32'h22, rd);
      wb(1'b1, 8'h40, 32'hFFFF_FFFF);
      wb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, rd);
      wb(1'b1, 8'h08, 32'h89AB_CDEF);
      wb(1'b1, 8'h0C, 32'h0123_4567);
      foreach (rows[n])
      begin
         wb(1'b1, 8'h00, {26'h0, rows[n].c});
         @(posedge sys_clk_i);
         rx_info_i <= to_info(rows[n]);
         rx_done_i <= 1'b1;
         @(posedge sys_clk_i);
         rx_done_i <= 1'b0;
         #1;
         chk("drop", 32'(rows[n].drop), 32'(frame_drop_o));
         chk("write", 32'(!rows[n].drop), 32'(desc_wr_o));
         chk("strip", 32'(rows[n].f[0]), 32'(strip_tag_o));
         if (!rows[n].drop)
         begin
            chk("w0", exp_w0(rx_info_i), desc_o.w0 & 32'h90FF_FFFF);
            chk("w0 own", 32'h0, desc_o.w0 & 32'h8000_0000);
            chk("w1", {15'h0, rows[n].f[0], 16'h0}, desc_o.w1 & 32'h0001_0000);
            if (rows[n].f[0])
               chk("tag", {18'h2, rows[n].len}, {16'h0, desc_o.w1[15:0]});
            chk("w2", 32'h89AB_CDEF, desc_o.w2);
            chk("w3", 32'h0123_4567, desc_o.w3);
         end
      end
      for (int i = 0; i < 2; i++)
      begin
         wb(1'b1, 8'h00, i ? 32'h22 : 32'h23);
         @(posedge sys_clk_i);
         ext_lpbk <= i[0];
         tx_en_i <= 1'b1;
         tx_d_i <= i ? 8'hC3 : 8'h5A;
         wait_sig(3, 1'b1);
         chk("loop data", i ? 32'hC3 : 32'h5A, {24'h0, mac_rxd_o});
         chk("phy tx en", 32'(i), 32'(phy_tx_en_o));
         @(posedge sys_clk_i);
         tx_en_i <= 1'b0;
         ext_lpbk <= 1'b0;
         wait_sig(3, 1'b0);
      end
      wb(1'b1, 8'h00, 32'h20);
      @(posedge sys_clk_i);
      tx_en_i <= 1'b1;
      tx_preamble_i <= 1'b1;
      line_dv <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      #1;
      chk("collision", 32'h1, 32'(collision_o));
      chk("jam in preamble", 32'h0, 32'(jam_o));
      @(posedge sys_clk_i);
      tx_preamble_i <= 1'b0;
      wait_sig(2, 1'b1);
      for (int i = 0; i < 2; i++)
      begin
         wb(1'b1, 8'h00, i ? 32'h22 : 32'h24);
         repeat (3) @(posedge sys_clk_i);
         #1;
         chk("no collision", 32'h0, 32'(collision_o));
      end
      @(posedge sys_clk_i);
      tx_en_i <= 1'b0;
      line_dv <= 1'b0;
      desc_avail_i <= 1'b0;
      pulse(1'b1, 16'h0003);
      repeat (4) @(posedge sys_clk_i);
      #1;
      chk("flow control off", 32'h0, {30'h0, pause_tx_req_o, tx_pause_hold_o});
      @(posedge sys_clk_i);
      autoneg_fc_i <= 1'b1;
      wait_sig(0, 1'b1);
      chk("pause stop", 32'hFFFF, {16'h0, pause_tx_time_o});
      wait_sig(0, 1'b0);
      pulse(1'b1, 16'h0003);
      wait_sig(1, 1'b1);
      @(posedge sys_clk_i);
      slow <= 1'b1;
      desc_avail_i <= 1'b1;
      wait_sig(0, 1'b1);
      chk("pause go", 32'h0, {16'h0, pause_tx_time_o});
      chk("hold during pause tx", 32'h1, 32'(tx_pause_hold_o));
      wait_sig(0, 1'b0);
      pulse(1'b1, 16'h0000);
      wait_sig(1, 1'b0);
      pulse(1'b1, 16'h0002);
      wait_sig(1, 1'b1);
      pulse(1'b0, 16'h0000);
      repeat (3) @(posedge sys_clk_i);
      #1;
      chk("hold after one slot", 32'h1, 32'(tx_pause_hold_o));
      pulse(1'b0, 16'h0000);
      wait_sig(1, 1'b0);
      @(posedge sys_clk_i);
      tx_busy_i <= 1'b1;
      pulse(1'b1, 16'h0001);
      repeat (4) @(posedge sys_clk_i);
      #1;
      chk("hold while busy", 32'h0, 32'(tx_pause_hold_o));
      @(posedge sys_clk_i);
      tx_busy_i <= 1'b0;
      wait_sig(1, 1'b1);
      pulse(1'b0, 16'h0000);
      wait_sig(1, 1'b0);
      wrap_up();
   end
endmodule
`default_nettype wire
